// *** frb_fbi_model.sv ***
// Behavioural framebuffer interface: logs read and write entries and
// returns one word per non-hold read. Assumes the unit's clock.
`timescale 1ns/1ns
`default_nettype none
module frb_fbi_model
  import frb_pkg::*;
(
  // Clock, reset and slow-down control
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  // Read address queue
  input wire logic raValid,
  output logic raReady,
  input wire logic [ADDR_W-1:0] raAddr,
  input wire logic raHold,
  // Write address queue
  input wire logic waValid,
  output logic waReady,
  input wire logic [ADDR_W-1:0] waAddr,
  input wire logic waStep,
  // Returned read words
  output logic rdValid,
  input wire logic rdReady,
  output logic [DATA_W-1:0] rdData
);
  logic [ADDR_W:0] raLog[$];
  logic [ADDR_W:0] waLog[$];
  logic [DATA_W-1:0] pend[$];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      raReady <= 1'b0;
      waReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 32'h00000000;
      pend.delete();
    end else begin
      raReady <= !stall;
      waReady <= !stall;
      if (raValid && raReady) begin
        raLog.push_back({raHold, raAddr});
        if (!raHold) pend.push_back({8'h3c, raAddr});
      end
      if (waValid && waReady) waLog.push_back({waStep, waAddr});
      // Released data line flips so stale words never look valid
      if (rdValid && rdReady) begin
        rdValid <= 1'b0;
        rdData <= ~rdData;
      end else if (!rdValid && pend.size() > 0 && !stall) begin
        rdValid <= 1'b1;
        rdData <= pend.pop_front();
      end
    end
  end
endmodule
`default_nettype wire

// *** frb_fifo.sv ***
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock; depth is a power of two of at least two.
`timescale 1ns/1ns
`default_nettype none
module frb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  // Drain side
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_check
    $error("frb_fifo depth must be a power of two, at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } frb_fifo_s;

  frb_fifo_s fifo_reg;
  frb_fifo_s fifo_next;
  logic doWr;
  logic doRd;

  assign wrReady = fifo_reg.count != (PW+1)'(DEPTH);
  assign rdValid = fifo_reg.count != '0;
  assign rdData = fifo_reg.mem[fifo_reg.rdPtr];
  assign doWr = wrValid && wrReady;
  assign doRd = rdValid && rdReady;

  always_comb begin
    fifo_next = fifo_reg;
    if (doWr) begin
      fifo_next.mem[fifo_reg.wrPtr] = wrData;
      fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
    end
    if (doRd) begin
      fifo_next.rdPtr = fifo_reg.rdPtr + 1'b1;
    end
    // Both at once leave the count unchanged
    if (doWr && !doRd) begin
      fifo_next.count = fifo_reg.count + 1'b1;
    end else if (doRd && !doWr) begin
      fifo_next.count = fifo_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end
endmodule
`default_nettype wire

// *** frb_pkg.sv ***
// Shared constants for the framebuffer read unit: message tags,
// mode word layout, register indices and queue sizes.
// Assumes a 9-bit tag, 32-bit data message stream on one clock.
package frb_pkg;

  localparam int TAG_W = 9;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;

  // State update group: upper tag bits match, low bits pick the register
  localparam logic [6:0] TAG_REG_GROUP = 7'h2c;
  localparam logic [1:0] REG_IDX_MODE = 2'h0;
  localparam logic [1:0] REG_IDX_SRC_DELTA = 2'h1;
  localparam logic [1:0] REG_IDX_BUF_DELTA = 2'h2;
  localparam logic [1:0] REG_IDX_WIN_ORIGIN = 2'h3;

  // Rasteriser walk group: upper tag bits match; prepare and fill tags sit outside it
  localparam logic [5:0] TAG_WALK_GROUP = 6'h01;
  localparam logic [8:0] TAG_ACTIVE_STEP = 9'h008;
  localparam logic [8:0] TAG_RENDER_PREPARE = 9'h020;
  localparam logic [8:0] TAG_BLOCK_FILL = 9'h021;

  // Output data word tags
  localparam logic [8:0] TAG_DST_READ = 9'h0c0;
  localparam logic [8:0] TAG_SRC_READ = 9'h0c1;
  localparam logic [8:0] TAG_RAW_UPLOAD = 9'h0c2;

  // read_unit_mode layout
  localparam int MODE_W = 14;
  localparam int MODE_FETCH_SRC = 0;
  localparam int MODE_FETCH_DST = 1;
  localparam int MODE_TOP_LEFT = 2;
  localparam int MODE_MSG_TYPE = 3;
  localparam int MODE_PP0 = 5;
  localparam int MODE_PP1 = 8;
  localparam int MODE_PP2 = 11;
  localparam int PP_W = 3;
  localparam int PP_SHIFT_BASE = 4;

  // Message type field values
  localparam logic [1:0] MSG_TYPE_DEFAULT = 2'h0;
  localparam logic [1:0] MSG_TYPE_RAW = 2'h1;

  // Coordinates inside an walk step data word
  localparam int COORD_X_LSB = 0;
  localparam int COORD_Y_LSB = 16;
  localparam int COORD_W = 16;

  // Reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] DELTA_RESET = 24'h000000;
  localparam logic [ADDR_W-1:0] ORIGIN_RESET = 24'h000000;

  // Message queue: tag, data, two fetch enables, raw flag
  localparam int MQ_W = TAG_W + DATA_W + 3;
  localparam int MQ_DEPTH = 8;

endpackage

// *** frb_read_unit.sv ***
// Framebuffer read unit: address generation toward the framebuffer
// interface and merging of returned read data into the message stream.
// Assumes upstream, framebuffer interface and downstream on this clock.
//
// Overview of operation
// - Buffer select delta is added to every computed pixel address.
// - Message type field picks destination/source words or, for a lone read, raw upload words.
// - Copy source delta held as 24-bit two's complement value.
// - Buffer select delta held as 24-bit two's complement value.
// - Window origin address held as 24-bit unsigned base.
// - State update messages load a local register and are dropped.
// - Render prepare pushes hold-reads entry to read address queue.
// - Render prepare and unknown messages queued with fetch enables cleared.
// - Block fill pushes destination write address, queued with enables cleared.
// - Walk step reads: none, source only or destination only per enables.
// - Both enables: destination address queued before source address.
// - After reads, write mode plus destination address go to write queue.
// - Walk step queued with current fetch enables and message type.
// - Every queue push stalls input until target queue has room.
// - Only the walk step tag of the rasteriser walk group is decoded; the rest pass through.
// - Image upload returns a lone destination or source read unconverted as a raw upload word.
// - Address arithmetic is 24-bit, wrapping, coordinates sign extended.
// - Mode bit picks origin: subtract Y offset bottom-left, add top-left.
// - Source address is destination address plus copy source delta.
// - Two reads emit destination word, then source word, then message.
`timescale 1ns/1ns
`default_nettype none
module frb_read_unit
  import frb_pkg::*;
#(
  parameter int MQ_DEPTH_P = MQ_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Incoming messages from the rasteriser side
  input wire logic inValid,
  output logic inReady,
  input wire logic [TAG_W-1:0] inTag,
  input wire logic [DATA_W-1:0] inData,
  // Read address queue
  output logic raValid,
  input wire logic raReady,
  output logic [ADDR_W-1:0] raAddr,
  output logic raHold,
  // Write address queue
  output logic waValid,
  input wire logic waReady,
  output logic [ADDR_W-1:0] waAddr,
  output logic waStep,
  // Returned read data
  input wire logic rdValid,
  output logic rdReady,
  input wire logic [DATA_W-1:0] rdData,
  // Outgoing messages
  output logic outValid,
  input wire logic outReady,
  output logic [TAG_W-1:0] outTag,
  output logic [DATA_W-1:0] outData
);

  typedef enum logic [2:0] {
    IN_IDLE = 3'b000,
    IN_HOLD = 3'b001,
    IN_RDDST = 3'b010,
    IN_RDSRC = 3'b011,
    IN_WA = 3'b100,
    IN_MQ = 3'b101
  } frb_in_st_e;

  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_RD1 = 2'b01,
    OUT_RD2 = 2'b10,
    OUT_MSG = 2'b11
  } frb_out_st_e;

  typedef struct packed {
    frb_in_st_e inSt;
    frb_out_st_e outSt;
    logic [MODE_W-1:0] mode;
    logic [ADDR_W-1:0] srcDelta;
    logic [ADDR_W-1:0] bufDelta;
    logic [ADDR_W-1:0] winOrigin;
    logic [TAG_W-1:0] msgTag;
    logic [DATA_W-1:0] msgData;
    logic [ADDR_W-1:0] dstAddr;
    logic [ADDR_W-1:0] srcAddr;
    logic [1:0] msgEn;
    logic msgRaw;
    logic inReady;
    logic raValid;
    logic [ADDR_W-1:0] raAddr;
    logic raHold;
    logic waValid;
    logic [ADDR_W-1:0] waAddr;
    logic waStep;
    logic rdReady;
    logic outValid;
    logic [TAG_W-1:0] outTag;
    logic [DATA_W-1:0] outData;
  } frb_state_s;

  if (MQ_DEPTH_P < 2) begin : g_check
    $error("frb_read_unit message queue needs at least two entries");
  end

  frb_state_s st_reg;
  frb_state_s st_next;

  // Message queue signals
  logic mqPush;
  logic mqRoom;
  logic [MQ_W-1:0] mqIn;
  logic mqHave;
  logic mqPop;
  logic [MQ_W-1:0] mqHead;
  logic [TAG_W-1:0] headTag;
  logic [DATA_W-1:0] headData;
  logic [1:0] headEn;
  logic headRaw;

  // Address path
  logic [ADDR_W-1:0] xExt;
  logic [ADDR_W-1:0] yExt;
  logic [ADDR_W-1:0] yOffset;
  logic [ADDR_W-1:0] dstCalc;
  logic [ADDR_W-1:0] srcCalc;
  logic accept;
  logic raFree;
  logic waFree;
  logic outFree;
  logic rdTake;

  // Y times screen width as a sum of up to three shifted terms
  function automatic logic [ADDR_W-1:0] yTimesWidth(input logic [ADDR_W-1:0] y,
                                                    input logic [MODE_W-1:0] m);
    logic [ADDR_W-1:0] acc;
    logic [PP_W-1:0] code;
    acc = '0;
    code = '0;
    for (int i = 0; i < 3; i++) begin
      code = m[MODE_PP0 + i*PP_W +: PP_W];
      if (code != '0) begin
        acc = acc + (y << (int'(code) + PP_SHIFT_BASE));
      end
    end
    return acc;
  endfunction

  assign xExt = ADDR_W'($signed(inData[COORD_X_LSB +: COORD_W]));
  assign yExt = ADDR_W'($signed(inData[COORD_Y_LSB +: COORD_W]));
  assign yOffset = yTimesWidth(yExt, st_reg.mode);

  always_comb begin
    if (st_reg.mode[MODE_TOP_LEFT]) begin
      dstCalc = st_reg.winOrigin + yOffset + xExt + st_reg.bufDelta;
    end else begin
      dstCalc = st_reg.winOrigin - yOffset + xExt + st_reg.bufDelta;
    end
  end

  assign srcCalc = dstCalc + st_reg.srcDelta;

  assign accept = inValid && st_reg.inReady;
  assign raFree = !st_reg.raValid || raReady;
  assign waFree = !st_reg.waValid || waReady;
  assign outFree = !st_reg.outValid || outReady;
  assign rdTake = rdValid && st_reg.rdReady;

  assign mqPush = st_reg.inSt == IN_MQ;
  assign mqIn = {st_reg.msgTag, st_reg.msgData, st_reg.msgEn, st_reg.msgRaw};
  assign {headTag, headData, headEn, headRaw} = mqHead;
  assign mqPop = st_reg.outSt == OUT_MSG && outFree;

  always_comb begin
    st_next = st_reg;
    if (raReady) begin
      st_next.raValid = 1'b0;
    end
    if (waReady) begin
      st_next.waValid = 1'b0;
    end
    if (outReady) begin
      st_next.outValid = 1'b0;
    end

    case (st_reg.inSt)
      IN_IDLE: begin
        if (accept) begin
          st_next.msgTag = inTag;
          st_next.msgData = inData;
          st_next.dstAddr = dstCalc;
          st_next.srcAddr = srcCalc;
          st_next.msgEn = 2'b00;
          st_next.msgRaw = 1'b0;
          if (inTag[TAG_W-1:2] == TAG_REG_GROUP) begin
            case (inTag[1:0])
              REG_IDX_MODE: st_next.mode = inData[MODE_W-1:0];
              REG_IDX_SRC_DELTA: st_next.srcDelta = inData[ADDR_W-1:0];
              REG_IDX_BUF_DELTA: st_next.bufDelta = inData[ADDR_W-1:0];
              REG_IDX_WIN_ORIGIN: st_next.winOrigin = inData[ADDR_W-1:0];
              default: st_next.mode = st_reg.mode;
            endcase
          end else if (inTag == TAG_RENDER_PREPARE) begin
            st_next.inSt = IN_HOLD;
          end else if (inTag == TAG_BLOCK_FILL) begin
            st_next.inSt = IN_WA;
          end else if (inTag == TAG_ACTIVE_STEP) begin
            st_next.msgEn = {st_reg.mode[MODE_FETCH_DST], st_reg.mode[MODE_FETCH_SRC]};
            st_next.msgRaw = st_reg.mode[MODE_MSG_TYPE +: 2] == MSG_TYPE_RAW;
            if (st_reg.mode[MODE_FETCH_DST]) begin
              st_next.inSt = IN_RDDST;
            end else if (st_reg.mode[MODE_FETCH_SRC]) begin
              st_next.inSt = IN_RDSRC;
            end else begin
              st_next.inSt = IN_WA;
            end
          end else begin
            // other walk and unknown messages pass; enables cleared
            st_next.inSt = IN_MQ;
          end
        end
      end
      IN_HOLD: begin
        if (raFree) begin
          st_next.raValid = 1'b1;
          st_next.raHold = 1'b1;
          st_next.raAddr = '0;
          st_next.inSt = IN_MQ;
        end
      end
      IN_RDDST: begin
        if (raFree) begin
          st_next.raValid = 1'b1;
          st_next.raHold = 1'b0;
          st_next.raAddr = st_reg.dstAddr;
          st_next.inSt = st_reg.msgEn[0] ? IN_RDSRC : IN_WA;
        end
      end
      IN_RDSRC: begin
        if (raFree) begin
          st_next.raValid = 1'b1;
          st_next.raHold = 1'b0;
          st_next.raAddr = st_reg.srcAddr;
          st_next.inSt = IN_WA;
        end
      end
      IN_WA: begin
        if (waFree) begin
          st_next.waValid = 1'b1;
          st_next.waAddr = st_reg.dstAddr;
          st_next.waStep = st_reg.msgTag == TAG_ACTIVE_STEP;
          st_next.inSt = IN_MQ;
        end
      end
      IN_MQ: begin
        if (mqRoom) begin
          st_next.inSt = IN_IDLE;
        end
      end
      default: st_next.inSt = IN_IDLE;
    endcase

    case (st_reg.outSt)
      OUT_IDLE: begin
        if (mqHave) begin
          if (headEn == 2'b00) begin
            st_next.outSt = OUT_MSG;
          end else if (headEn[1]) begin
            st_next.outSt = OUT_RD1;
          end else begin
            st_next.outSt = OUT_RD2;
          end
        end
      end
      OUT_RD1: begin
        if (rdTake) begin
          st_next.outValid = 1'b1;
          st_next.outData = rdData;
          // first of two is destination; raw upload only for a lone read
          if (headRaw && headEn != 2'b11) begin
            st_next.outTag = TAG_RAW_UPLOAD;
          end else begin
            st_next.outTag = TAG_DST_READ;
          end
          st_next.outSt = headEn[0] ? OUT_RD2 : OUT_MSG;
        end
      end
      OUT_RD2: begin
        if (rdTake) begin
          st_next.outValid = 1'b1;
          st_next.outData = rdData;
          if (headRaw && headEn != 2'b11) begin
            st_next.outTag = TAG_RAW_UPLOAD;
          end else begin
            st_next.outTag = TAG_SRC_READ;
          end
          st_next.outSt = OUT_MSG;
        end
      end
      OUT_MSG: begin
        if (outFree) begin
          st_next.outValid = 1'b1;
          st_next.outTag = headTag;
          st_next.outData = headData;
          st_next.outSt = OUT_IDLE;
        end
      end
      default: st_next.outSt = OUT_IDLE;
    endcase

    // Ready only when the idle input stage and empty output slot follow
    st_next.inReady = st_next.inSt == IN_IDLE;
    st_next.rdReady = (st_next.outSt == OUT_RD1 || st_next.outSt == OUT_RD2) &&
                      !st_next.outValid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.inSt <= IN_IDLE;
      st_reg.outSt <= OUT_IDLE;
      st_reg.mode <= MODE_RESET;
      st_reg.srcDelta <= DELTA_RESET;
      st_reg.bufDelta <= DELTA_RESET;
      st_reg.winOrigin <= ORIGIN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Decouples address issue from data return
  frb_fifo #(
    .WIDTH(MQ_W),
    .DEPTH(MQ_DEPTH_P)
  ) u_mq (
    .clk(clk),
    .rst(rst),
    .wrValid(mqPush),
    .wrReady(mqRoom),
    .wrData(mqIn),
    .rdValid(mqHave),
    .rdReady(mqPop),
    .rdData(mqHead)
  );

  assign inReady = st_reg.inReady;
  assign raValid = st_reg.raValid;
  assign raAddr = st_reg.raAddr;
  assign raHold = st_reg.raHold;
  assign waValid = st_reg.waValid;
  assign waAddr = st_reg.waAddr;
  assign waStep = st_reg.waStep;
  assign rdReady = st_reg.rdReady;
  assign outValid = st_reg.outValid;
  assign outTag = st_reg.outTag;
  assign outData = st_reg.outData;
endmodule
`default_nettype wire

// *** frb_read_unit_checker.sv ***
// Port checker for the framebuffer read unit.
// Assumes it is bound to every unit instance and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module frb_read_unit_checker
  import frb_pkg::*;
#(
  parameter int MQ_DEPTH_P = MQ_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Input stream
  input wire logic inValid,
  input wire logic inReady,
  input wire logic [TAG_W-1:0] inTag,
  input wire logic [DATA_W-1:0] inData,
  // Address queues
  input wire logic raValid,
  input wire logic raReady,
  input wire logic [ADDR_W-1:0] raAddr,
  input wire logic raHold,
  input wire logic waValid,
  input wire logic waReady,
  input wire logic [ADDR_W-1:0] waAddr,
  input wire logic waStep,
  // Read data and output
  input wire logic rdValid,
  input wire logic rdReady,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [TAG_W-1:0] outTag,
  input wire logic [DATA_W-1:0] outData
);
  logic take;
  logic isReg;
  assign take = inValid && inReady;
  assign isReg = inTag[8:2] == TAG_REG_GROUP;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_inStall; take && !isReg |=> !inReady; endproperty
  a_inStall: assert property (p_inStall)
    else $error("input not stalled after take");
  property p_regKeep; take && isReg |=> inReady; endproperty
  a_regKeep: assert property (p_regKeep)
    else $error("register message stalled input");
  // no queue traffic; an older entry may still be waiting at the take
  property p_regQuiet; take && isReg && !raValid && !waValid |=> !raValid && !waValid;
  endproperty
  a_regQuiet: assert property (p_regQuiet)
    else $error("queue busy at register take");
  property p_raHold; raValid && !raReady |=> raValid && $stable(raAddr) && $stable(raHold);
  endproperty
  a_raHold: assert property (p_raHold)
    else $error("read entry changed while waiting");
  property p_waHold; waValid && !waReady |=> waValid && $stable(waAddr) && $stable(waStep);
  endproperty
  a_waHold: assert property (p_waHold)
    else $error("write entry changed while waiting");
  property p_outHold; outValid && !outReady |=> outValid && $stable({outTag, outData});
  endproperty
  a_outHold: assert property (p_outHold)
    else $error("output changed while stalled");
  property p_holdAddr; raValid && raHold |-> raAddr == '0; endproperty
  a_holdAddr: assert property (p_holdAddr)
    else $error("hold entry address not zero");
  property p_prep; take && inTag == TAG_RENDER_PREPARE |-> ##[1:40] raValid && raHold;
  endproperty
  a_prep: assert property (p_prep)
    else $error("no hold entry after prepare");
  property p_fill; take && inTag == TAG_BLOCK_FILL |-> ##[1:40] waValid && !waStep; endproperty
  a_fill: assert property (p_fill)
    else $error("no fill write entry");
  property p_step; take && inTag == TAG_ACTIVE_STEP |-> ##[1:40] waValid && waStep; endproperty
  a_step: assert property (p_step)
    else $error("no step write entry");
  property p_rdOut; rdValid && rdReady |=> outValid && outData == $past(rdData); endproperty
  a_rdOut: assert property (p_rdOut)
    else $error("read word not forwarded unchanged");
endmodule
bind frb_read_unit frb_read_unit_checker #(.MQ_DEPTH_P(MQ_DEPTH_P)) u_chk (
  .clk(clk), .rst(rst), .inValid(inValid), .inReady(inReady), .inTag(inTag),
  .inData(inData), .raValid(raValid), .raReady(raReady), .raAddr(raAddr), .raHold(raHold),
  .waValid(waValid), .waReady(waReady), .waAddr(waAddr), .waStep(waStep),
  .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .outValid(outValid),
  .outReady(outReady), .outTag(outTag), .outData(outData));
`default_nettype wire

// *** frb_read_unit_tb_top.sv ***
// Self-checking bench for the framebuffer read unit.
// Assumes the behavioural framebuffer interface model on the far side.
`timescale 1ns/1ns
`default_nettype none
module frb_read_unit_tb_top
  import frb_pkg::*;
;
  localparam int CW = TAG_W + DATA_W;
  logic clk, rst, inValid, inReady, raValid, raReady, raHold, waValid, waReady, waStep;
  logic rdValid, rdReady, outValid, outReady, stall, ok;
  logic [TAG_W-1:0] inTag, outTag;
  logic [DATA_W-1:0] inData, rdData, outData, d;
  logic [ADDR_W-1:0] raAddr, waAddr, win, bufD, srcD, a, s;
  logic [MODE_W-1:0] mode;
  logic [CW-1:0] outLog[$];
  int fails, testsRun, cnt;
  frb_read_unit #(.MQ_DEPTH_P(MQ_DEPTH)) DUT (.clk(clk), .rst(rst), .inValid(inValid),
    .inReady(inReady), .inTag(inTag), .inData(inData), .raValid(raValid), .raReady(raReady),
    .raAddr(raAddr), .raHold(raHold), .waValid(waValid), .waReady(waReady), .waAddr(waAddr),
    .waStep(waStep), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
    .outValid(outValid), .outReady(outReady), .outTag(outTag), .outData(outData));
  frb_fbi_model u_fbi (.clk(clk), .rst(rst), .stall(stall), .raValid(raValid),
    .raReady(raReady), .raAddr(raAddr), .raHold(raHold), .waValid(waValid),
    .waReady(waReady), .waAddr(waAddr), .waStep(waStep), .rdValid(rdValid),
    .rdReady(rdReady), .rdData(rdData));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (outValid === 1'b1 && outReady === 1'b1) outLog.push_back({outTag, outData});
  end
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Holds the message until the edge where inReady is high, giving up after lim cycles
  task automatic send(input logic [TAG_W-1:0] t, input logic [DATA_W-1:0] v, input int lim);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    inValid = 1'b1;
    inTag = t;
    inData = v;
    while (inReady !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = inReady === 1'b1;
    if (ok) begin
      @(posedge clk);
      #1;
    end
    inValid = 1'b0;
  endtask
  task automatic msg(input logic [TAG_W-1:0] t, input logic [DATA_W-1:0] v);
    send(t, v, 200);
    if (!ok) check('0, 1);
  endtask
  task automatic setReg(input logic [1:0] idx, input logic [DATA_W-1:0] v);
    msg({TAG_REG_GROUP, idx}, v);
  endtask
  task automatic waitOut(input int n);
    int k;
    k = 0;
    while (outLog.size() < n && k < 300) begin
      @(posedge clk);
      k++;
    end
    #1;
  endtask
  task automatic expOut(input logic [TAG_W-1:0] t, input logic [DATA_W-1:0] v);
    check(outLog.size() > 0 ? outLog.pop_front() : 'x, {t, v});
  endtask
  task automatic expQ(ref logic [ADDR_W:0] q[$], input logic [ADDR_W:0] e);
    check(CW'(q.size() > 0 ? q.pop_front() : 'x), CW'(e));
  endtask
  function automatic logic [ADDR_W-1:0] dstAddr(input logic [DATA_W-1:0] v);
    logic [ADDR_W-1:0] x, y, yo;
    logic [PP_W-1:0] c;
    x = ADDR_W'(signed'(v[COORD_X_LSB +: COORD_W]));
    y = ADDR_W'(signed'(v[COORD_Y_LSB +: COORD_W]));
    yo = '0;
    for (int i = 0; i < 3; i++) begin
      c = mode[MODE_PP0 + i * PP_W +: PP_W];
      if (c != 0) yo = yo + (y << (c + PP_SHIFT_BASE));
    end
    return (mode[MODE_TOP_LEFT] ? win + yo : win - yo) + x + bufD;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    printVerdict();
  end
  initial begin
    fails = 0;
    testsRun = 0;
    {rst, inValid, inTag, inData, outReady, stall} = {1'b1, 1'b0, 9'h000, 32'h0, 1'b1, 1'b0};
    {mode, win, bufD, srcD} = {MODE_RESET, 24'h000100, 24'h000000, 24'hffff00};
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    mode[MODE_PP0 +: PP_W] = 3'h6;
    mode[MODE_PP1 +: PP_W] = 3'h3;
    setReg(REG_IDX_WIN_ORIGIN, {8'h00, win});
    setReg(REG_IDX_BUF_DELTA, {8'h00, bufD});
    setReg(REG_IDX_SRC_DELTA, {8'h00, srcD});
    repeat (10) @(posedge clk);
    check(CW'(outLog.size()), '0);
    // all fetch setups, stalls on odd rows
    for (int i = 0; i < 8; i++) begin
      mode[MODE_FETCH_SRC] = i[0];
      mode[MODE_FETCH_DST] = i[1];
      mode[MODE_TOP_LEFT] = i[0];
      mode[MODE_MSG_TYPE +: 2] = i[2] ? MSG_TYPE_RAW : MSG_TYPE_DEFAULT;
      setReg(REG_IDX_MODE, DATA_W'(mode));
      d = {16'hfffd - 16'(i), 16'hfff8 + 16'(i)};
      fork
        msg(TAG_ACTIVE_STEP, d);
        begin
          stall = i[0];
          outReady = !i[1];
          repeat (12) @(posedge clk);
          #1;
          {stall, outReady} = 2'b01;
        end
      join
      waitOut(1 + i[0] + i[1]);
      a = dstAddr(d);
      s = a + srcD;
      if (i[1]) expQ(u_fbi.raLog, {1'b0, a});
      if (i[0]) expQ(u_fbi.raLog, {1'b0, s});
      check(CW'(u_fbi.raLog.size()), '0);
      expQ(u_fbi.waLog, {1'b1, a});
      if (i[1:0] == 2'b11) begin
        expOut(TAG_DST_READ, {8'h3c, a});
        expOut(TAG_SRC_READ, {8'h3c, s});
      end else if (i[1]) begin
        expOut(i[2] ? TAG_RAW_UPLOAD : TAG_DST_READ, {8'h3c, a});
      end else if (i[0]) begin
        expOut(i[2] ? TAG_RAW_UPLOAD : TAG_SRC_READ, {8'h3c, s});
      end
      expOut(TAG_ACTIVE_STEP, d);
    end
    msg(TAG_RENDER_PREPARE, 32'h12345678);
    waitOut(1);
    expQ(u_fbi.raLog, {1'b1, 24'h000000});
    expOut(TAG_RENDER_PREPARE, 32'h12345678);
    // Nonzero buffer delta only for the multi-buffer style fill
    bufD = 24'h040000;
    setReg(REG_IDX_BUF_DELTA, {8'h00, bufD});
    msg(TAG_BLOCK_FILL, d);
    waitOut(1);
    expQ(u_fbi.waLog, {1'b0, dstAddr(d)});
    expOut(TAG_BLOCK_FILL, d);
    for (int t = 9; t < 16; t++) begin
      msg(TAG_W'(t), 32'(t));
      waitOut(1);
      expOut(TAG_W'(t), 32'(t));
    end
    check(CW'(u_fbi.raLog.size() + u_fbi.waLog.size()), '0);
    outReady = 1'b0;
    cnt = 0;
    for (int k = 0; k < 20; k++) begin
      send(9'h1f0, 32'(k), 30);
      if (!ok) break;
      cnt++;
    end
    check(CW'(cnt >= MQ_DEPTH && cnt < 20), 1);
    outReady = 1'b1;
    waitOut(cnt);
    for (int k = 0; k < cnt; k++) expOut(9'h1f0, 32'(k));
    check(CW'(outLog.size()), '0);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    {mode, win, bufD, srcD} = {MODE_RESET, ORIGIN_RESET, DELTA_RESET, DELTA_RESET};
    msg(TAG_ACTIVE_STEP, d);
    waitOut(1);
    expQ(u_fbi.waLog, {1'b1, dstAddr(d)});
    expOut(TAG_ACTIVE_STEP, d);
    printVerdict();
  end
endmodule
`default_nettype wire
